// File: verilog/bcsq_defs.vh
// bcsq_defs.vh: opcodes, field masks, steps and timing constants for the sequence-op decoder
// assumes inclusion by bare name from verilog/ design files
`ifndef BCSQ_DEFS_VH
`define BCSQ_DEFS_VH

// ==========================================================
// opcodes handled here
`define BCSQ_OP_LOAD_FRAME      16'h000E
`define BCSQ_OP_START_FRAME     16'h000F
`define BCSQ_OP_PUSH_TSTAMP     16'h0010
`define BCSQ_OP_PUSH_BLKSTATE   16'h0011
`define BCSQ_OP_PUSH_LITERAL    16'h0012
`define BCSQ_OP_PUSH_MEMWORD    16'h0013
`define BCSQ_OP_AWAIT_TRIGGER   16'h0014
`define BCSQ_OP_RUN_AND_SWAP    16'h0015

// ==========================================================
// fields and steps
`define BCSQ_SWAP_BIT           4
`define BCSQ_SWAP_MASK          16'h0010
`define BCSQ_INSTR_STEP         16'h0002

// ==========================================================
// frame timer scaling
`define BCSQ_FRAME_LSB_NS       100000
`define BCSQ_CLK_PERIOD_NS      25
`define BCSQ_FRAME_LSB_CYC      (`BCSQ_FRAME_LSB_NS / `BCSQ_CLK_PERIOD_NS)

`endif

// File: verilog/bcsq_seq_ops.v
// bcsq_seq_ops.v: instruction decoder for frame timer, queue push, trigger wait and
// execute-and-flip opcodes of a bus-controller instruction-list engine.
// assumes an outer engine that fetches opcode/parameter pairs and serves
// memory, the message processor and the queue with valid/ready style handshakes.
//
// Overview of operation
// - false condition skips the op and fetches the next opcode, except on 0015.
// - opcode 000E loads frame timer from parameter, 100 us per LSB.
// - opcode 000F starts frame countdown from the frame timer register.
// - opcode 0010 pushes the time tag value onto the queue.
// - opcode 0011 pushes the last message block status word.
// - opcode 0012 pushes the parameter word itself.
// - opcode 0013 reads memory at parameter address and pushes the word.
// - opcode 0014 true stalls until trigger rises, then continues.
// - opcode 0014 false continues at once.
// - opcode 0015 always runs the message at the parameter block address.
// - after 0015 message, true condition writes back address with bit 4 inverted.
// - next run of that flip uses old address XOR 0010h.
// - false condition on 0015 leaves the stored address unchanged.
`timescale 1ns/1ps
`include "bcsq_defs.vh"

module bcsq_seq_ops (
  // clock and reset
  input  wire        ref_clk,
  input  wire        reset,
  // instruction from the fetch stage
  input  wire        instr_valid,
  input  wire [15:0] instr_opcode,
  input  wire [15:0] instr_param,
  input  wire [15:0] instr_addr,
  input  wire        cond_true,
  output wire        instr_ready,
  output reg  [15:0] next_ptr_q,
  output reg         next_ptr_valid_q,
  // state from other engine parts
  input  wire [15:0] time_tag_value,
  input  wire [15:0] block_status_word,
  input  wire        external_trigger_in,
  // general purpose queue
  output reg         queue_push_q,
  output reg  [15:0] queue_data_q,
  input  wire        queue_ready,
  // shared memory
  output reg         mem_rd_q,
  output reg         mem_wr_q,
  output reg  [15:0] mem_addr_q,
  output reg  [15:0] mem_wdata_q,
  input  wire        mem_done,
  input  wire [15:0] mem_rdata,
  // message processor
  output reg         msg_start_q,
  output reg  [15:0] msg_block_addr_q,
  input  wire        msg_done,
  // frame timer
  output reg  [15:0] frame_period_q,
  output reg  [15:0] frame_count_q,
  output reg         frame_running_q,
  output wire        frame_expired
);

  // ==========================================================
  // states
  localparam [2:0] ST_IDLE  = 3'd0;
  localparam [2:0] ST_PUSH  = 3'd1;
  localparam [2:0] ST_MRD   = 3'd2;
  localparam [2:0] ST_TRIG  = 3'd3;
  localparam [2:0] ST_MSG   = 3'd4;
  localparam [2:0] ST_WBACK = 3'd5;
  localparam [2:0] ST_DONE  = 3'd6;

  localparam [31:0] LSB_CYC = `BCSQ_FRAME_LSB_CYC;

  reg [2:0]  state_q;
  reg        cond_q;
  reg [15:0] addr_q;
  reg [15:0] param_q;
  reg        trig_prev_q;
  reg [31:0] tick_q;

  assign instr_ready   = (state_q == ST_IDLE);
  assign frame_expired = frame_running_q & (frame_count_q == 16'h0000);

  // address of the parameter word of an instruction at a
  function [15:0] param_addr;
    input [15:0] a;
    begin
      param_addr = a + 16'h0001;
    end
  endfunction

  // ==========================================================
  // trigger edge history, kept live so an edge in a wait is seen at once
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      trig_prev_q <= 1'b0;
    end else begin
      trig_prev_q <= external_trigger_in;
    end
  end

  // ==========================================================
  // frame countdown, one decrement per 100 us tick
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      frame_count_q   <= 16'h0000;
      frame_running_q <= 1'b0;
      tick_q          <= 32'h0000_0000;
    end else if (instr_ready && instr_valid && cond_true &&
                 instr_opcode == `BCSQ_OP_START_FRAME) begin
      frame_count_q   <= frame_period_q;
      frame_running_q <= 1'b1;
      tick_q          <= 32'h0000_0000;
    end else if (frame_running_q && frame_count_q != 16'h0000) begin
      if (tick_q == LSB_CYC - 32'h0000_0001) begin
        tick_q        <= 32'h0000_0000;
        frame_count_q <= frame_count_q - 16'h0001;
      end else begin
        tick_q <= tick_q + 32'h0000_0001;
      end
    end
  end

  // ==========================================================
  // instruction sequencer
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state_q          <= ST_IDLE;
      cond_q           <= 1'b0;
      addr_q           <= 16'h0000;
      param_q          <= 16'h0000;
      next_ptr_q       <= 16'h0000;
      next_ptr_valid_q <= 1'b0;
      queue_push_q     <= 1'b0;
      queue_data_q     <= 16'h0000;
      mem_rd_q         <= 1'b0;
      mem_wr_q         <= 1'b0;
      mem_addr_q       <= 16'h0000;
      mem_wdata_q      <= 16'h0000;
      msg_start_q      <= 1'b0;
      msg_block_addr_q <= 16'h0000;
      frame_period_q   <= 16'h0000;
    end else begin
      next_ptr_valid_q <= 1'b0;
      msg_start_q      <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (instr_valid) begin
            addr_q  <= instr_addr;
            param_q <= instr_param;
            cond_q  <= cond_true;
            state_q <= ST_DONE;
            case (instr_opcode)
              `BCSQ_OP_LOAD_FRAME: begin
                if (cond_true) frame_period_q <= instr_param;
              end
              `BCSQ_OP_PUSH_TSTAMP: begin
                if (cond_true) begin
                  queue_data_q <= time_tag_value;
                  queue_push_q <= 1'b1;
                  state_q      <= ST_PUSH;
                end
              end
              `BCSQ_OP_PUSH_BLKSTATE: begin
                if (cond_true) begin
                  queue_data_q <= block_status_word;
                  queue_push_q <= 1'b1;
                  state_q      <= ST_PUSH;
                end
              end
              `BCSQ_OP_PUSH_LITERAL: begin
                if (cond_true) begin
                  queue_data_q <= instr_param;
                  queue_push_q <= 1'b1;
                  state_q      <= ST_PUSH;
                end
              end
              `BCSQ_OP_PUSH_MEMWORD: begin
                if (cond_true) begin
                  mem_addr_q <= instr_param;
                  mem_rd_q   <= 1'b1;
                  state_q    <= ST_MRD;
                end
              end
              `BCSQ_OP_AWAIT_TRIGGER: begin
                if (cond_true) state_q <= ST_TRIG;
              end
              `BCSQ_OP_RUN_AND_SWAP: begin
                msg_block_addr_q <= instr_param;
                msg_start_q      <= 1'b1;
                state_q          <= ST_MSG;
              end
              // false or start-frame falls straight to done
              default: state_q <= ST_DONE;
            endcase
          end
        end
        ST_PUSH: begin
          // held until the queue accepts, stalling the engine
          if (queue_ready) begin
            queue_push_q <= 1'b0;
            state_q      <= ST_DONE;
          end
        end
        ST_MRD: begin
          if (mem_done) begin
            mem_rd_q     <= 1'b0;
            queue_data_q <= mem_rdata;
            queue_push_q <= 1'b1;
            state_q      <= ST_PUSH;
          end
        end
        ST_TRIG: begin
          if (external_trigger_in && !trig_prev_q) state_q <= ST_DONE;
        end
        ST_MSG: begin
          if (msg_done) begin
            // flip bit 4 and write back
            if (cond_q) begin
              mem_addr_q  <= param_addr(addr_q);
              mem_wdata_q <= param_q ^ `BCSQ_SWAP_MASK;
              mem_wr_q    <= 1'b1;
              state_q     <= ST_WBACK;
            end else begin
              state_q <= ST_DONE;
            end
          end
        end
        ST_WBACK: begin
          if (mem_done) begin
            mem_wr_q <= 1'b0;
            state_q  <= ST_DONE;
          end
        end
        ST_DONE: begin
          next_ptr_q       <= addr_q + `BCSQ_INSTR_STEP;
          next_ptr_valid_q <= 1'b1;
          state_q          <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

endmodule // bcsq_seq_ops

// File: test/bcsq_seq_ops_assertions.sv
// bcsq_seq_ops_assertions.sv: port-level checks for the sequence-op decoder
// assumes it is bound onto every bcsq_seq_ops instance, one clock domain
`timescale 1ns/1ps
module bcsq_sva (
  // clock, reset and instruction
  input wire        ref_clk, reset, instr_valid, cond_true, instr_ready,
  input wire [15:0] instr_opcode, instr_param, instr_addr, next_ptr_q,
  // results
  input wire        next_ptr_valid_q, queue_push_q, mem_wr_q, msg_start_q,
  input wire        frame_running_q, external_trigger_in,
  input wire [15:0] queue_data_q, time_tag_value, mem_addr_q, mem_wdata_q,
  input wire [15:0] msg_block_addr_q, frame_period_q, frame_count_q
);
  // ==========================================================
  // captured instruction
  reg  [15:0] addr_h, par_h;
  reg         cnd_h;
  wire        take = instr_valid && instr_ready;
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      addr_h <= 16'h0000;
      par_h  <= 16'h0000;
      cnd_h  <= 1'b0;
    end else if (take) begin
      addr_h <= instr_addr;
      par_h  <= instr_param;
      cnd_h  <= cond_true;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  sequence take_s(op);
    take && instr_opcode == op;
  endsequence
  sequence trig_low_s;
    !external_trigger_in [*3];
  endsequence
  busy_after_take_a: assert property (take |=> !instr_ready)
    else $error("ready high after take");
  ptr_step_a: assert property (next_ptr_valid_q |-> next_ptr_q == addr_h + 16'h0002)
    else $error("pointer step wrong");
  false_skip_a: assert property (take && !cond_true && instr_opcode != 16'h0015
    |-> ##[1:3] next_ptr_valid_q) else $error("false condition not skipped");
  frame_load_a: assert property (take_s(16'h000E) ##0 cond_true
    |-> ##[1:3] frame_period_q == par_h) else $error("frame period not loaded");
  frame_start_a: assert property (take_s(16'h000F) ##0 cond_true
    |-> ##[1:3] frame_running_q && frame_count_q == frame_period_q) else $error("no start");
  tstamp_push_a: assert property (take_s(16'h0010) ##0 cond_true
    |-> ##[1:2] queue_push_q && queue_data_q == time_tag_value) else $error("bad tag push");
  literal_push_a: assert property (take_s(16'h0012) ##0 cond_true
    |-> ##[1:2] queue_push_q && queue_data_q == par_h) else $error("bad literal push");
  msg_launch_a: assert property (take_s(16'h0015)
    |-> ##[1:2] msg_start_q && msg_block_addr_q == par_h) else $error("message not run");
  swap_write_a: assert property (mem_wr_q |-> cnd_h && mem_addr_q == addr_h + 16'h0001
    && mem_wdata_q == (par_h ^ 16'h0010)) else $error("bad swap write");
  trig_hold_a: assert property (take_s(16'h0014) ##0 cond_true ##1 trig_low_s
    |-> !next_ptr_valid_q) else $error("wait ended without edge");
endmodule // bcsq_sva
bind bcsq_seq_ops bcsq_sva u_sva (
  .ref_clk             (ref_clk),
  .reset               (reset),
  .instr_valid         (instr_valid),
  .cond_true           (cond_true),
  .instr_ready         (instr_ready),
  .instr_opcode        (instr_opcode),
  .instr_param         (instr_param),
  .instr_addr          (instr_addr),
  .next_ptr_q          (next_ptr_q),
  .next_ptr_valid_q    (next_ptr_valid_q),
  .queue_push_q        (queue_push_q),
  .mem_wr_q            (mem_wr_q),
  .msg_start_q         (msg_start_q),
  .frame_running_q     (frame_running_q),
  .external_trigger_in (external_trigger_in),
  .queue_data_q        (queue_data_q),
  .time_tag_value      (time_tag_value),
  .mem_addr_q          (mem_addr_q),
  .mem_wdata_q         (mem_wdata_q),
  .msg_block_addr_q    (msg_block_addr_q),
  .frame_period_q      (frame_period_q),
  .frame_count_q       (frame_count_q)
);

// File: test/bcsq_far_model.sv
// bcsq_far_model.sv: memory, queue and message processor beside the decoder
// assumes one request pending at a time; dly sets the answer latency
`timescale 1ns/1ps
module bcsq_far_model (
  // clock and reset
  input  wire        ref_clk,
  input  wire        reset,
  // requests
  input  wire [3:0]  dly,
  input  wire        mem_rd_q, mem_wr_q, queue_push_q, msg_start_q,
  input  wire [15:0] mem_addr_q,
  // answers
  output reg         ack_q,
  output wire [15:0] mem_rdata
);
  reg  [3:0]  cnt_q;
  reg  [15:0] pat_q;
  reg         msg_q;
  wire        busy = mem_rd_q | mem_wr_q | queue_push_q | msg_q;
  assign mem_rdata = (ack_q && mem_rd_q) ? ~mem_addr_q : pat_q;
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      cnt_q <= 4'h0;
      msg_q <= 1'b0;
      ack_q <= 1'b0;
      pat_q <= 16'h0000;
    end else begin
      pat_q <= pat_q + 16'h1357;
      msg_q <= msg_start_q | (msg_q & ~ack_q);
      ack_q <= busy && !ack_q && cnt_q == dly;
      cnt_q <= (!busy || ack_q || cnt_q == dly) ? 4'h0 : cnt_q + 4'h1;
    end
  end
endmodule // bcsq_far_model

// File: test/tb_top.sv
// tb_top.sv: directed scenarios for the sequence-op decoder
// assumes the far model answers memory and queue requests dly+1 cycles after they rise, messages dly+2
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin num_errors++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end
module tb_top;
  reg         ref_clk = 1'b0, reset = 1'b1, instr_valid = 1'b0, cond_true = 1'b0;
  reg         external_trigger_in = 1'b0;
  reg  [15:0] instr_opcode = 16'h0000, instr_param = 16'h0000, instr_addr = 16'h0000;
  reg  [15:0] time_tag_value = 16'hA5A5, block_status_word = 16'h5A5A, qlast, wlast, walast;
  reg  [3:0]  dly = 4'h0;
  wire        instr_ready, next_ptr_valid_q, queue_push_q, mem_rd_q, mem_wr_q, msg_start_q;
  wire        frame_running_q, frame_expired, ack_q;
  wire [15:0] next_ptr_q, queue_data_q, mem_addr_q, mem_wdata_q, mem_rdata;
  wire [15:0] msg_block_addr_q, frame_period_q, frame_count_q;
  wire        mem_done = ack_q, queue_ready = ack_q, msg_done = ack_q;
  integer     num_errors = 0, check_count = 0, cyc, npush = 0, nwr = 0, nmsg = 0;
  bcsq_seq_ops i_dut (.*);
  bcsq_far_model i_far (.*);
  always @(posedge ref_clk) begin
    if (queue_push_q && queue_ready) begin npush++; qlast = queue_data_q; end
    if (mem_wr_q && mem_done) begin nwr++; wlast = mem_wdata_q; walast = mem_addr_q; end
    if (msg_start_q) nmsg++;
  end
  task issue(input [15:0] o, p, a, input c);
    begin
      @(negedge ref_clk);
      {instr_opcode, instr_param, instr_addr, cond_true, instr_valid} = {o, p, a, c, 1'b1};
      @(negedge ref_clk);
      instr_valid = 1'b0;
      cyc = 0;
      while (next_ptr_valid_q !== 1'b1 && cyc < 900) begin @(negedge ref_clk); cyc++; end
      `CHK("next_ptr", a + 16'h0002, next_ptr_q)
    end
  endtask
  task t_skip;
    integer i;
    for (i = 14; i < 21; i++) begin
      issue(i[15:0], 16'h0033, 16'h0100, 1'b0);
      `CHK("skip_push", 0, npush)
      `CHK("skip_fast", 1, cyc < 4)
    end
  endtask
  task t_frame;
    begin
      issue(16'h000E, 16'h0003, 16'h0110, 1'b1);
      `CHK("period", 16'h0003, frame_period_q)
      issue(16'h000F, 16'hFFFF, 16'h0112, 1'b1);
      `CHK("count", 16'h0003, frame_count_q)
      repeat (4100) @(negedge ref_clk);
      `CHK("tick", 16'h0002, frame_count_q)
      `CHK("not_expired", 0, frame_expired)
      repeat (8000) @(negedge ref_clk);
      `CHK("count_end", 16'h0000, frame_count_q)
      `CHK("running", 1, frame_running_q)
      `CHK("expired", 1, frame_expired)
    end
  endtask
  task t_push;
    reg [15:0] ev [0:3];
    integer i;
    begin
      {ev[0], ev[1], ev[2], ev[3]} = {16'hA5A5, 16'h5A5A, 16'h1234, 16'hEDCB};
      dly = 4'h3;
      for (i = 0; i < 4; i++) begin
        issue(16'h0010 + i[15:0], 16'h1234, 16'h0120, 1'b1);
        `CHK("push_n", i + 1, npush)
        `CHK("push_d", ev[i], qlast)
      end
    end
  endtask
  task t_trig;
    begin
      fork
        issue(16'h0014, 16'h0000, 16'h0130, 1'b1);
        begin repeat (20) @(negedge ref_clk); external_trigger_in = 1'b1; end
      join
      external_trigger_in = 1'b0;
      `CHK("trig_wait", 1, cyc > 18)
    end
  endtask
  task t_swap;
    begin
      issue(16'h0015, 16'h0120, 16'h0200, 1'b1);
      `CHK("swap_a", 16'h0201, walast)
      `CHK("swap_d", 16'h0130, wlast)
      issue(16'h0015, wlast, 16'h0200, 1'b1);
      `CHK("swap_blk", 16'h0130, msg_block_addr_q)
      `CHK("swap_back", 16'h0120, wlast)
      issue(16'h0015, 16'h0120, 16'h0200, 1'b0);
      `CHK("keep_n", 2, nwr)
      `CHK("msg_n", 3, nmsg)
    end
  endtask
  task close_out;
    begin
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  initial forever #12.5 ref_clk = ~ref_clk;
  initial begin
    repeat (2) @(negedge ref_clk);
    reset = 1'b0;
    t_skip;
    t_frame;
    t_push;
    t_trig;
    t_swap;
    close_out;
  end
  // three frame ticks of 4000 cycles plus the short scenarios, with margin
  initial begin #600000; num_errors++; close_out; end
endmodule // tb_top
